// ===== verilog/relay_mux_pkg.sv
package relay_mux_pkg;

  localparam int NUM_DRIVES = 24;
  localparam int NUM_BANKS = 2;
  localparam int BANK_SIZE = 10;
  localparam int NUM_CHANNELS = 20;
  localparam int CHAN_W = 7;

  localparam logic [CHAN_W-1:0] CHAN_FIRST = 7'h00;
  localparam logic [CHAN_W-1:0] CHAN_LAST = 7'h13;
  localparam logic [CHAN_W-1:0] CHAN_SPLIT = 7'h0A;
  localparam logic [CHAN_W-1:0] CHAN_SENSE_A = 7'h5B;
  localparam logic [CHAN_W-1:0] CHAN_SENSE_B = 7'h5C;
  localparam logic [CHAN_W-1:0] CHAN_SOURCE_A = 7'h5D;
  localparam logic [CHAN_W-1:0] CHAN_SOURCE_B = 7'h5E;

  localparam logic [NUM_CHANNELS-1:0] CHANNELS_RESET = 20'h00000;
  localparam logic [NUM_BANKS-1:0] ROUTE_RESET = 2'h0;
  localparam logic ISOLATION_RESET = 1'b1;

  typedef enum logic [2:0] {
    OP_OPEN = 3'h0,
    OP_CLOSE = 3'h1,
    OP_MEASURE_VOLTS = 3'h2,
    OP_MEASURE_OHMS = 3'h3,
    OP_OPEN_ALL = 3'h4
  } cmd_op_t;

  typedef struct packed {
    logic valid;
    cmd_op_t op;
    logic [CHAN_W-1:0] channel;
  } cmd_t;

  typedef struct packed {
    logic [NUM_CHANNELS-1:0] channel_closed;
    logic [NUM_BANKS-1:0] sense_closed;
    logic [NUM_BANKS-1:0] source_closed;
  } switch_state_t;

  typedef struct packed {
    logic ok;
    logic is_bank;
    logic bank;
    logic [3:0] index;
    logic is_sense;
    logic is_source;
  } decode_t;

endpackage : relay_mux_pkg

// ===== verilog/channel_decode.sv
module channel_decode
  import relay_mux_pkg::*;
(
  input wire logic [relay_mux_pkg::CHAN_W-1:0] channel,
  output relay_mux_pkg::decode_t dec
);

  always_comb begin
    dec = '0;
    if (channel <= CHAN_LAST) begin
      dec.ok = 1'b1;
      dec.is_bank = 1'b1;
      if (channel >= CHAN_SPLIT) begin
        dec.bank = 1'b1;
        dec.index = 4'(channel - CHAN_SPLIT);
      end else begin
        dec.bank = 1'b0;
        dec.index = channel[3:0];
      end
    end else if (channel == CHAN_SENSE_A || channel == CHAN_SENSE_B) begin
      dec.ok = 1'b1;
      dec.is_sense = 1'b1;
      dec.bank = (channel == CHAN_SENSE_B);
    end else if (channel == CHAN_SOURCE_A || channel == CHAN_SOURCE_B) begin
      dec.ok = 1'b1;
      dec.is_source = 1'b1;
      dec.bank = (channel == CHAN_SOURCE_B);
    end
  end

endmodule : channel_decode

// ===== verilog/relay_bank_channel_select.sv
module relay_bank_channel_select (
  input wire logic core_clk,
  input wire logic resetn,
  input relay_mux_pkg::cmd_t cmd,
  input wire logic backplane_isolation_setting,
  output logic cmd_ready,
  output logic cmd_error,
  output relay_mux_pkg::switch_state_t state,
  output logic [relay_mux_pkg::NUM_DRIVES-1:0] switch_drive,
  output logic [relay_mux_pkg::NUM_BANKS-1:0] backplane_sense,
  output logic [relay_mux_pkg::NUM_BANKS-1:0] backplane_source
);
  import relay_mux_pkg::*;

  // ******************************
  // Isolation input synchroniser
  // ******************************
  logic iso_meta;
  logic iso_sync;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      iso_meta <= ISOLATION_RESET;
      iso_sync <= ISOLATION_RESET;
    end else begin
      iso_meta <= backplane_isolation_setting;
      iso_sync <= iso_meta;
    end
  end

  // ******************************
  // Command decode
  // ******************************
  decode_t dec;

  channel_decode u_decode (
    .channel(cmd.channel),
    .dec(dec)
  );

  logic [NUM_CHANNELS-1:0] chan_onehot;
  logic [NUM_CHANNELS-1:0] bank_mask;

  always_comb begin
    chan_onehot = '0;
    bank_mask = '0;
    if (dec.is_bank) begin
      chan_onehot[5'(dec.bank ? 5'h0A : 5'h00) + 5'(dec.index)] = 1'b1;
      if (dec.bank) begin
        bank_mask[NUM_CHANNELS-1:BANK_SIZE] = '1;
      end else begin
        bank_mask[BANK_SIZE-1:0] = '1;
      end
    end
  end

  assign cmd_ready = 1'b1;

  // ******************************
  // Switch state
  // ******************************
  switch_state_t next_state;
  logic accept;

  assign accept = cmd.valid && (dec.ok || cmd.op == OP_OPEN_ALL);

  always_comb begin
    next_state = state;
    unique case (cmd.op)
      OP_OPEN: begin
        if (dec.is_bank) begin
          next_state.channel_closed = state.channel_closed & ~chan_onehot;
        end
        if (dec.is_sense) begin
          next_state.sense_closed[dec.bank] = 1'b0;
        end
        if (dec.is_source) begin
          next_state.source_closed[dec.bank] = 1'b0;
        end
      end
      OP_CLOSE: begin
        // Open the rest of the bank and close the channel in the same cycle
        if (dec.is_bank) begin
          next_state.channel_closed = (state.channel_closed & ~bank_mask) | chan_onehot;
        end
        if (dec.is_sense) begin
          next_state.sense_closed[dec.bank] = 1'b1;
        end
        if (dec.is_source) begin
          next_state.source_closed[dec.bank] = 1'b1;
        end
      end
      OP_MEASURE_VOLTS, OP_MEASURE_OHMS: begin
        // Route only the measured bank, isolate the other
        if (dec.is_bank) begin
          next_state.channel_closed = (state.channel_closed & ~bank_mask) | chan_onehot;
          next_state.sense_closed = '0;
          next_state.source_closed = '0;
          next_state.sense_closed[dec.bank] = 1'b1;
          next_state.source_closed[dec.bank] = (cmd.op == OP_MEASURE_OHMS);
        end
      end
      OP_OPEN_ALL: begin
        next_state.channel_closed = CHANNELS_RESET;
        next_state.sense_closed = ROUTE_RESET;
        next_state.source_closed = ROUTE_RESET;
      end
      default: begin
        next_state = state;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state.channel_closed <= CHANNELS_RESET;
      state.sense_closed <= ROUTE_RESET;
      state.source_closed <= ROUTE_RESET;
    end else if (accept) begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cmd_error <= 1'b0;
    end else begin
      cmd_error <= cmd.valid && !accept;
    end
  end

  // ******************************
  // Drives and backplane paths
  // ******************************
  // One drive per switch feeds its high, low and guard relays
  assign switch_drive = {state.source_closed, state.sense_closed, state.channel_closed};

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      backplane_sense <= ROUTE_RESET;
      backplane_source <= ROUTE_RESET;
    end else begin
      backplane_sense <= iso_sync ? state.sense_closed : ROUTE_RESET;
      backplane_source <= iso_sync ? state.source_closed : ROUTE_RESET;
    end
  end

endmodule : relay_bank_channel_select

// ===== dv/relay_ctrl_model.sv
module relay_ctrl_model
  import relay_mux_pkg::*;
(
  input wire logic core_clk,
  output relay_mux_pkg::cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cmd = '0;
  task automatic send(input cmd_op_t op, input logic [CHAN_W-1:0] ch);
    @(posedge core_clk);
    cmd <= '{1'b1, op, ch};
  endtask : send
  task automatic idle();
    @(posedge core_clk);
    cmd <= '0;
  endtask : idle
  // Low-level commands close only the bank's sense relay (and source relay for ohms), no channel
  task automatic low_volts(input logic [CHAN_W-1:0] ch);
    send(OP_CLOSE, (ch < CHAN_SPLIT) ? CHAN_SENSE_A : CHAN_SENSE_B);
  endtask : low_volts
  task automatic low_ohms(input logic [CHAN_W-1:0] ch);
    send(OP_CLOSE, (ch < CHAN_SPLIT) ? CHAN_SENSE_A : CHAN_SENSE_B);
    send(OP_CLOSE, (ch < CHAN_SPLIT) ? CHAN_SOURCE_A : CHAN_SOURCE_B);
  endtask : low_ohms
endmodule : relay_ctrl_model

// ===== dv/relay_sel_checker.sv
module relay_sel_checker
  import relay_mux_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input relay_mux_pkg::cmd_t cmd,
  input wire logic backplane_isolation_setting,
  input wire logic cmd_ready,
  input wire logic cmd_error,
  input relay_mux_pkg::switch_state_t state,
  input wire logic [relay_mux_pkg::NUM_DRIVES-1:0] switch_drive,
  input wire logic [relay_mux_pkg::NUM_BANKS-1:0] backplane_sense,
  input wire logic [relay_mux_pkg::NUM_BANKS-1:0] backplane_source
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire logic cl = cmd.valid && cmd.op == OP_CLOSE;
  wire logic ok = cmd.channel <= CHAN_LAST || (cmd.channel >= CHAN_SENSE_A && cmd.channel <= CHAN_SOURCE_B);
  drive_map_a: assert property (switch_drive == {state.source_closed, state.sense_closed, state.channel_closed})
    else $error("drive map");
  one_per_bank_a: assert property ($onehot0(state.channel_closed[9:0]) && $onehot0(state.channel_closed[19:10]))
    else $error("bank");
  hold_idle_a: assert property (!cmd.valid |=> $stable(state)) else $error("hold");
  bad_chan_a: assert property (cmd.valid && !ok && cmd.op != OP_OPEN_ALL |=> cmd_error && $stable(state))
    else $error("bad");
  close_chan_a: assert property (cl && cmd.channel <= CHAN_LAST |=> state.channel_closed[$past(cmd.channel[4:0])])
    else $error("close");
  sense_route_a: assert property (cl && cmd.channel == CHAN_SENSE_A |=> state.sense_closed[0]) else $error("s");
  source_route_a: assert property (cl && cmd.channel == CHAN_SOURCE_A |=> state.source_closed[0]) else $error("r");
  iso_cut_a: assert property (!backplane_isolation_setting [*4] |-> !(|{backplane_sense, backplane_source}))
    else $error("cut");
  iso_pass_a: assert property (backplane_isolation_setting [*4] |-> backplane_source == $past(state.source_closed))
    else $error("pass");
  measure_cmd_volts_a: assert property (cmd.valid && cmd.op == OP_MEASURE_VOLTS && cmd.channel >= CHAN_SPLIT && ok
    && cmd.channel <= CHAN_LAST |=> state.sense_closed == 2'h2 && state.source_closed == 2'h0) else $error("measure_cmd");
  cover property (cl);
  cover property (cmd_error);
  cover property (cmd.valid && cmd.op == OP_MEASURE_VOLTS);
endmodule : relay_sel_checker

bind relay_bank_channel_select relay_sel_checker chk_u (.core_clk, .resetn, .cmd, .backplane_isolation_setting,
  .cmd_ready, .cmd_error, .state, .switch_drive, .backplane_sense, .backplane_source);

// ===== dv/relay_bank_channel_select_test.sv
module relay_bank_channel_select_test import relay_mux_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("Error %s exp %h got %h", n, e, g); end end
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic iso = 1'b1;
  cmd_t cmd;
  logic cmd_ready, cmd_error;
  switch_state_t state;
  logic [23:0] drive;
  logic [1:0] bps, bpr;
  int n_errors = 0;
  int tests_run = 0;
  relay_ctrl_model ctrl_u (.core_clk, .cmd);
  relay_bank_channel_select dut_u (.core_clk, .resetn, .cmd, .backplane_isolation_setting(iso), .cmd_ready,
    .cmd_error, .state, .switch_drive(drive), .backplane_sense(bps), .backplane_source(bpr));
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic go(input cmd_op_t op, input logic [6:0] ch);
    ctrl_u.send(op, ch);
    ctrl_u.idle();
    #1;
  endtask : go
  task automatic t_bank();
    ctrl_u.low_volts(7'h03);
    ctrl_u.send(OP_CLOSE, 7'h03);
    go(OP_CLOSE, 7'h05);
    `CHK("drive", 24'h100020, drive)
    go(OP_CLOSE, 7'h0F);
    `CHK("drive", 24'h108020, drive)
    @(posedge core_clk);
    #1;
    `CHK("bp", 4'h4, {bps, bpr})
    $display("t_bank done");
  endtask : t_bank
  task automatic t_measure_cmd();
    go(OP_OPEN_ALL, 7'h00);
    go(OP_MEASURE_VOLTS, 7'h0C);
    `CHK("drive", 24'h201000, drive)
    @(posedge core_clk);
    #1;
    `CHK("bp", 4'h8, {bps, bpr})
    go(OP_MEASURE_OHMS, 7'h02);
    `CHK("drive", 24'h501004, drive)
    go(OP_OPEN, 7'h02);
    `CHK("drive", 24'h501000, drive)
    go(OP_OPEN, 7'h5B);
    `CHK("drive", 24'h401000, drive)
    $display("t_measure_cmd done");
  endtask : t_measure_cmd
  task automatic t_ohms_bad();
    go(OP_OPEN_ALL, 7'h00);
    ctrl_u.low_ohms(7'h00);
    go(OP_CLOSE, 7'h00);
    `CHK("drive", 24'h500001, drive)
    go(OP_CLOSE, 7'h14);
    `CHK("err", 1'b1, cmd_error)
    go(OP_CLOSE, 7'h5F);
    `CHK("drive", 24'h500001, drive)
    $display("t_ohms_bad done");
  endtask : t_ohms_bad
  task automatic t_iso();
    @(posedge core_clk);
    iso <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("bp", 4'h0, {bps, bpr})
    `CHK("drive", 24'h500001, drive)
    @(posedge core_clk);
    iso <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("bp", 4'h5, {bps, bpr})
    $display("t_iso done");
  endtask : t_iso
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #100us;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    #1;
    `CHK("drive", 24'h000000, drive)
    `CHK("ready", 1'b1, cmd_ready)
    t_bank();
    t_measure_cmd();
    t_ohms_bad();
    t_iso();
    end_of_test();
  end
endmodule : relay_bank_channel_select_test
